// *** inc/ohi_pkg.sv ***
// Shared constants and types of the host interface of the display module
package ohi_pkg;

   // Data path widths and buffer depth
   localparam int         OHI_BYTE_W     = 8;
   localparam int         OHI_WORD_W     = 9;
   localparam int         OHI_FIFO_DEPTH = 8;

   // Strap codes on {bus_select_a, bus_select_b}
   localparam logic [1:0] OHI_STRAP_SERIAL  = 2'h0;
   localparam logic [1:0] OHI_STRAP_SER_ALT = 2'h1;
   localparam logic [1:0] OHI_STRAP_SELEN   = 2'h2;
   localparam logic [1:0] OHI_STRAP_STROBE  = 2'h3;

   // Cycles after reset release before the synchronised straps are trusted
   localparam logic [1:0] OHI_STRAP_SETTLE  = 2'h2;
   localparam logic [1:0] OHI_WARM_MAX      = 2'h3;

   // Serial framing and reset values
   localparam logic [2:0] OHI_SER_LAST_BIT  = 3'h7;
   localparam logic [2:0] OHI_SER_FIRST_BIT = 3'h0;
   localparam logic [7:0] OHI_RESET_BYTE    = 8'h00;

   // Interface modes
   typedef enum logic [1:0] {
      OHI_MODE_SERIAL = 2'b00,
      OHI_MODE_SELEN  = 2'b01,
      OHI_MODE_STROBE = 2'b10
   } ohi_mode_t;

endpackage : ohi_pkg

// *** rtl/ohi_fifo.sv ***
// Byte buffer between the host port and the controller
`timescale 1ns/10ps
module ohi_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Filling side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Draining side
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   localparam int          AW       = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0]   count;
   } ohi_fifo_state_t;

   ohi_fifo_state_t   s;
   ohi_fifo_state_t   next_s;
   logic [WIDTH-1:0]  mem [DEPTH];
   logic              do_push;
   logic              do_pop;

   // Pointer advance with wrap at the depth
   function automatic logic [AW-1:0] ohi_next_ptr(input logic [AW-1:0] p);
      ohi_next_ptr = (p == LAST_PTR) ? '0 : AW'(p + 1'b1);
   endfunction : ohi_next_ptr

   // Flags and handshakes
   assign in_ready  = (s.count != FULL_CNT);
   assign out_valid = (s.count != '0);
   assign out_data  = mem[s.rd_ptr];
   assign do_push   = in_valid && in_ready;
   assign do_pop    = out_valid && out_ready;

   // Next state of pointers and fill count
   always_comb begin
      next_s = s;
      if (do_push) begin
         next_s.wr_ptr = ohi_next_ptr(s.wr_ptr);
      end
      if (do_pop) begin
         next_s.rd_ptr = ohi_next_ptr(s.rd_ptr);
      end
      if (do_push && !do_pop) begin
         next_s.count = s.count + 1'b1;
      end else if (do_pop && !do_push) begin
         next_s.count = s.count - 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Storage array
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[s.wr_ptr] <= in_data;
      end
   end

endmodule : ohi_fifo

// *** rtl/ohi_port.sv ***
// Host bus port of the display module: two parallel modes and a serial mode
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Data-command select high during an access marks the byte as display data.
// - Data-command select low during an access marks the byte as a command.
// - In select-enable mode the write pin high means read, low means write.
// - In select-enable mode a transfer runs while enable is high and select low.
// - In strobe mode a write strobe low with chip select low writes a byte.
// - In strobe mode a read strobe low with chip select low drives the data.
// - Parallel modes use an eight-bit two-way data bus.
// - Serial mode: data line one is serial data, data line zero the clock.
// - Nothing is taken or driven while chip select is high.
// - The mode comes from two straps and stays fixed until reset.
// - Reset low initialises all controller state.
module ohi_port
   import ohi_pkg::*;
#(
   parameter int FIFO_DEPTH = OHI_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // Mode straps
   input  wire logic                  bus_select_a,
   input  wire logic                  bus_select_b,
   // Host bus pins
   input  wire logic                  cs_b,
   input  wire logic                  data_command_select,
   input  wire logic                  strobe_wr,
   input  wire logic                  strobe_rd,
   input  wire logic [OHI_BYTE_W-1:0] host_data_lines_in,
   output logic [OHI_BYTE_W-1:0]      host_data_lines_out,
   output logic                       host_data_lines_oe,
   // Controller side
   output logic                       byte_valid,
   output logic [OHI_BYTE_W-1:0]      byte_data,
   output logic                       byte_is_data,
   input  wire logic                  byte_ready,
   input  wire logic [OHI_BYTE_W-1:0] read_byte,
   output logic                       read_start,
   output logic                       host_busy,
   output logic                       overrun
);

   typedef struct packed {
      logic                  cs1, cs2, dc1, dc2, wr1, wr2, rd1, rd2;
      logic [OHI_BYTE_W-1:0] d1, d2;
      logic                  bsa1, bsa2, bsb1, bsb2;
      logic [1:0]            warm;
      logic                  strap_done;
      ohi_mode_t             mode;
      logic                  p_cs, p_wr, p_rd, p_sclk;
      logic [OHI_BYTE_W-1:0] shreg;
      logic [2:0]            bitcnt;
      logic                  push;
      logic [OHI_WORD_W-1:0] push_word;
      logic                  oe;
      logic [OHI_BYTE_W-1:0] dout;
      logic                  read_start;
      logic                  busy;
      logic                  overrun;
   } ohi_port_state_t;

   ohi_port_state_t       s;
   ohi_port_state_t       next_s;
   logic                  fifo_in_ready;
   logic [OHI_WORD_W-1:0] fifo_out_data;
   logic                  fifo_out_valid;
   logic                  sclk;
   logic                  serial_data_in;
   logic                  sel;

   // Strap code to interface mode
   function automatic ohi_mode_t ohi_strap_mode(input logic [1:0] code);
      case (code)
         OHI_STRAP_SELEN:   ohi_strap_mode = OHI_MODE_SELEN;
         OHI_STRAP_STROBE:  ohi_strap_mode = OHI_MODE_STROBE;
         OHI_STRAP_SERIAL:  ohi_strap_mode = OHI_MODE_SERIAL;
         default:           ohi_strap_mode = OHI_MODE_SERIAL;
      endcase
   endfunction : ohi_strap_mode

   // Serial pins share the data lines; chip select active low
   assign sclk = s.d2[0];
   assign serial_data_in = s.d2[1];
   assign sel  = !s.cs2;

   //////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_s = s;
      // Two-flop synchronisers on every pin
      next_s.cs1  = cs_b;
      next_s.cs2  = s.cs1;
      next_s.dc1  = data_command_select;
      next_s.dc2  = s.dc1;
      next_s.wr1  = strobe_wr;
      next_s.wr2  = s.wr1;
      next_s.rd1  = strobe_rd;
      next_s.rd2  = s.rd1;
      next_s.d1   = host_data_lines_in;
      next_s.d2   = s.d1;
      next_s.bsa1 = bus_select_a;
      next_s.bsa2 = s.bsa1;
      next_s.bsb1 = bus_select_b;
      next_s.bsb2 = s.bsb1;
      // Previous levels for edge detection
      next_s.p_cs   = s.cs2;
      next_s.p_wr   = s.wr2;
      next_s.p_rd   = s.rd2;
      next_s.p_sclk = sclk;
      next_s.push       = 1'b0;
      next_s.read_start = 1'b0;
      next_s.oe         = 1'b0;
      next_s.busy       = !fifo_in_ready;
      // Lost byte when the buffer refused it
      if (s.push && !fifo_in_ready) begin
         next_s.overrun = 1'b1;
      end
      // Strap capture once, after the synchronisers settle
      if (s.warm != OHI_WARM_MAX) begin
         next_s.warm = s.warm + 2'h1;
      end
      if (!s.strap_done && s.warm == OHI_STRAP_SETTLE) begin
         next_s.mode       = ohi_strap_mode({s.bsa2, s.bsb2});
         next_s.strap_done = 1'b1;
      end
      if (s.strap_done) begin
         case (s.mode)
            OHI_MODE_SELEN: begin
               // Read while enable high, direction pin high
               if (s.rd2 && sel && s.wr2) begin
                  next_s.oe = 1'b1;
                  if (!s.p_rd) begin
                     next_s.dout       = read_byte;
                     next_s.read_start = 1'b1;
                  end
               end
               // Write taken as enable closes, direction pin low
               if (s.p_rd && !s.rd2 && !s.p_cs && !s.wr2) begin
                  next_s.push      = 1'b1;
                  next_s.push_word = {s.dc2, s.d2};
               end
            end
            OHI_MODE_STROBE: begin
               // Read while read strobe low
               if (!s.rd2 && sel) begin
                  next_s.oe = 1'b1;
                  if (s.p_rd) begin
                     next_s.dout       = read_byte;
                     next_s.read_start = 1'b1;
                  end
               end
               // Write taken as write strobe rises
               if (!s.p_wr && s.wr2 && !s.p_cs) begin
                  next_s.push      = 1'b1;
                  next_s.push_word = {s.dc2, s.d2};
               end
            end
            OHI_MODE_SERIAL: begin
               // Chip select high aborts a partial byte
               if (!sel) begin
                  next_s.bitcnt = OHI_SER_FIRST_BIT;
               end else if (sclk && !s.p_sclk) begin
                  next_s.shreg  = {s.shreg[OHI_BYTE_W-2:0], serial_data_in};
                  next_s.bitcnt = s.bitcnt + 3'h1;
                  if (s.bitcnt == OHI_SER_LAST_BIT) begin
                     next_s.push      = 1'b1;
                     next_s.push_word = {s.dc2, s.shreg[OHI_BYTE_W-2:0], serial_data_in};
                  end
               end
            end
            default: begin
               next_s.oe = 1'b0;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s      <= '0;
         s.cs1  <= 1'b1;
         s.cs2  <= 1'b1;
         s.p_cs <= 1'b1;
         s.mode <= OHI_MODE_SERIAL;
         s.dout <= OHI_RESET_BYTE;
      end else begin
         s <= next_s;
      end
   end

   // Received bytes wait here for the controller
   ohi_fifo #(
      .WIDTH (OHI_WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (s.push),
      .in_data   (s.push_word),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (byte_ready)
   );

   // Outputs
   assign host_data_lines_out = s.dout;
   assign host_data_lines_oe  = s.oe;
   assign byte_valid          = fifo_out_valid;
   assign byte_data           = fifo_out_data[OHI_BYTE_W-1:0];
   assign byte_is_data        = fifo_out_data[OHI_BYTE_W];
   assign read_start          = s.read_start;
   assign host_busy           = s.busy;
   assign overrun             = s.overrun;

   //////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   drive_needs_cs_a : assert property (s.oe |-> $past(!s.cs2))
      else $error("data lines driven without chip select");
   tag_data_a : assert property (s.push && s.push_word[8] |-> $past(s.dc2))
      else $error("display byte without select high");
   tag_cmd_a : assert property (s.push && !s.push_word[8] |-> $past(!s.dc2))
      else $error("command byte without select low");
   selen_dir_a : assert property (s.oe && s.mode == OHI_MODE_SELEN |-> $past(s.wr2))
      else $error("read drive with direction pin low");
   selen_write_a : assert property (s.strap_done && s.mode == OHI_MODE_SELEN && s.p_rd && !s.rd2
      && !s.p_cs && !s.wr2 |=> s.push)
      else $error("select-enable write not taken");
   strobe_write_a : assert property (s.strap_done && s.mode == OHI_MODE_STROBE && !s.p_wr && s.wr2
      && !s.p_cs |=> s.push)
      else $error("strobe write not taken");
   strobe_read_a : assert property (s.strap_done && s.mode == OHI_MODE_STROBE && !s.rd2 && sel
      |=> s.oe)
      else $error("strobe read not driven");
   read_value_a : assert property (s.read_start |-> s.dout == $past(read_byte) ##1 s.oe[*1])
      else $error("read byte not presented");
   serial_quiet_a : assert property (s.strap_done && s.mode == OHI_MODE_SERIAL |=> !s.oe)
      else $error("data lines driven in serial mode");
   mode_fixed_a : assert property (s.strap_done |=> $stable(s.mode) && s.strap_done)
      else $error("mode changed after capture");
   serial_byte_a : assert property (s.mode == OHI_MODE_SERIAL && s.push
      |-> $past(s.bitcnt) == OHI_SER_LAST_BIT && s.bitcnt == OHI_SER_FIRST_BIT)
      else $error("serial byte pushed at wrong bit");

   // Main scenarios
   selen_push_c  : cover property (s.mode == OHI_MODE_SELEN && s.push);
   strobe_push_c : cover property (s.mode == OHI_MODE_STROBE && s.push);
   serial_push_c : cover property (s.mode == OHI_MODE_SERIAL && s.push);
   read_c        : cover property (s.read_start ##1 s.oe);
   overrun_c     : cover property ($rose(s.overrun));

endmodule : ohi_port

// *** test/ohi_host_model.sv ***
// Host microcontroller model driving the bus pins of the display module
`timescale 1ns/10ps
module ohi_host_model
   import ohi_pkg::*;
(
   // Clock
   input  wire logic                  clk,
   // Pins towards the device
   output logic                       cs_b,
   output logic                       dcs,
   output logic                       swr,
   output logic                       srd,
   output logic [OHI_BYTE_W-1:0]      host_d,
   output logic                       host_en,
   // Resolved data lines
   input  wire logic [OHI_BYTE_W-1:0] pin_d
);
   localparam int PH = 4;  // Cycles per phase, above the three the device needs

   // Let n edges pass, then step just after the last
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // Quiet bus: strobes inactive, serial clock low
   task automatic idle(input logic selen);
      cs_b = 1'b1;
      dcs = 1'b0;
      swr = 1'b1;
      srd = ~selen;
      host_en = 1'b1;
      host_d = 8'h00;
   endtask : idle

   // One parallel write; sel low leaves chip select high
   task automatic par_write(input logic selen, input logic sel, input logic dc,
                            input logic [7:0] d);
      cs_b = ~sel;
      dcs = dc;
      host_d = d;
      swr = 1'b0;
      srd = 1'b1;  // Enable high, or read strobe kept idle
      tick(PH);
      swr = selen ? 1'b0 : 1'b1;
      srd = ~selen;
      tick(PH);
      cs_b = 1'b1;
      host_d = ~d;  // Hold time over: stale data shows inverted
      tick(PH);
   endtask : par_write

   // One parallel read; the host releases the lines meanwhile
   task automatic par_read(input logic selen, output logic [7:0] got);
      cs_b = 1'b0;
      host_en = 1'b0;
      swr = 1'b1;
      srd = selen;
      tick(PH + 2);
      got = pin_d;
      srd = ~selen;
      tick(PH);
      cs_b = 1'b1;
      host_en = 1'b1;
      tick(PH);
   endtask : par_read

   // Serial frame of nb bits, most significant first, clock idle low
   task automatic ser_byte(input logic dc, input logic [7:0] d, input int nb);
      cs_b = 1'b0;
      dcs = dc;
      for (int i = 7; i > 7 - nb; i--) begin
         host_d = {6'h00, d[i], 1'b0};
         tick(PH);
         host_d[0] = 1'b1;
         tick(PH);
      end
      host_d = {6'h00, ~d[0], 1'b0};
      tick(PH);
      cs_b = 1'b1;
      tick(PH);
   endtask : ser_byte
endmodule : ohi_host_model

// *** test/testbench.sv ***
// Self-checking bench of the host port in all three bus modes
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
 $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench
   import ohi_pkg::*;
;
   // Clock, reset, straps and pins
   logic        clk, rst_b, bus_select_a, bus_select_b;
   logic        cs_b, dcs, swr, srd, host_en, oe;
   logic [7:0]  host_d, pin_d, dout, byte_data, read_byte;
   // Controller side and bench state
   logic        byte_valid, byte_is_data, byte_ready, read_start, host_busy, overrun;
   logic        hold_rdy;
   logic [8:0]  exp_w;
   logic [31:0] st = 32'h7e25e1d1;
   logic [31:0] st_rdy = 32'h7e25e1d1;
   logic [8:0]  exp_q[$];
   int          n_fail = 0, n_tests = 0, n_rs = 0, n_cyc = 0;

   // Wire level: device drives when enabled, a released line shows inverse
   assign pin_d = oe ? dout : (host_en ? host_d : ~host_d);

   ohi_port #(.FIFO_DEPTH(OHI_FIFO_DEPTH)) u_ohi_port (
      .clk(clk), .rst_b(rst_b), .bus_select_a(bus_select_a), .bus_select_b(bus_select_b),
      .cs_b(cs_b), .data_command_select(dcs), .strobe_wr(swr), .strobe_rd(srd),
      .host_data_lines_in(pin_d), .host_data_lines_out(dout), .host_data_lines_oe(oe),
      .byte_valid(byte_valid), .byte_data(byte_data), .byte_is_data(byte_is_data),
      .byte_ready(byte_ready), .read_byte(read_byte), .read_start(read_start),
      .host_busy(host_busy), .overrun(overrun));

   ohi_host_model u_ohi_host_model (
      .clk(clk), .cs_b(cs_b), .dcs(dcs), .swr(swr), .srd(srd),
      .host_d(host_d), .host_en(host_en), .pin_d(pin_d));

   // Clock
   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   // Random source
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // Controller stalls at random unless held
   always @(posedge clk) begin
      #1;
      st_rdy = lfsr_next(st_rdy);
      byte_ready = ~hold_rdy & st_rdy[0];
   end

   // Pops must match the oldest expected byte; hang guard
   always @(posedge clk) begin
      n_cyc++;
      if (read_start === 1'b1) n_rs++;
      if (rst_b && byte_valid === 1'b1 && byte_ready === 1'b1) begin
         exp_w = 9'bx;
         if (exp_q.size() > 0) exp_w = exp_q.pop_front();
         `CHK({byte_is_data, byte_data}, exp_w)
      end
      if (n_cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("TB: %0d checks, %0d mismatches", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic done_test(input string name);
      $display("TB: test %s done at %0t", name, $time);
   endtask : done_test

   // Reset with given straps, outputs checked while held
   task automatic do_reset(input logic a, input logic b);
      rst_b = 1'b0;
      bus_select_a = a;
      bus_select_b = b;
      u_ohi_host_model.idle(a & ~b);
      u_ohi_host_model.tick(4);
      `CHK({oe, byte_valid, read_start, host_busy, overrun}, 5'h00)
      exp_q.delete();
      rst_b = 1'b1;
      u_ohi_host_model.tick(8);
   endtask : do_reset

   task automatic wr(input logic selen, input logic dc, input logic [7:0] d);
      exp_q.push_back({dc, d});
      u_ohi_host_model.par_write(selen, 1'b1, dc, d);
   endtask : wr

   task automatic rd(input logic selen);
      logic [7:0] got;
      int         rs0;
      rs0 = n_rs;
      st = lfsr_next(st);
      read_byte = st[7:0];
      u_ohi_host_model.par_read(selen, got);
      `CHK(got, read_byte)
      `CHK(n_rs - rs0, 1)
   endtask : rd

   // Let the controller take everything, then expect an empty buffer
   task automatic drain();
      int n;
      hold_rdy = 1'b0;
      n = 0;
      while ((exp_q.size() > 0 || byte_valid !== 1'b0) && n < 400) begin
         u_ohi_host_model.tick(1);
         n++;
      end
      `CHK(exp_q.size(), 0)
      `CHK(byte_valid, 1'b0)
   endtask : drain

   // Main sequence
   initial begin
      read_byte = 8'h00;
      hold_rdy = 1'b1;
      byte_ready = 1'b0;
      do_reset(1'b1, 1'b1);
      for (int i = 0; i < 6; i++) begin
         st = lfsr_next(st);
         wr(1'b0, st[8], (i == 0) ? 8'hff : st[7:0]);
      end
      rd(1'b0);
      rd(1'b0);
      drain();
      u_ohi_host_model.par_write(1'b0, 1'b0, 1'b1, 8'h3c);
      `CHK({byte_valid, oe, overrun}, 3'h0)
      bus_select_a = 1'b0;
      wr(1'b0, 1'b0, 8'h81);
      drain();
      done_test("strobe");
      hold_rdy = 1'b1;
      for (int i = 0; i < 8; i++) wr(1'b0, i[0], 8'h10 + 8'(i));
      u_ohi_host_model.par_write(1'b0, 1'b1, 1'b1, 8'hee);
      `CHK({host_busy, overrun}, 2'h3)
      drain();
      `CHK(overrun, 1'b1)
      hold_rdy = 1'b1;
      wr(1'b0, 1'b1, 8'h55);
      done_test("overrun");
      do_reset(1'b1, 1'b0);
      for (int i = 0; i < 4; i++) begin
         st = lfsr_next(st);
         wr(1'b1, st[9], (i == 0) ? 8'h00 : st[7:0]);
      end
      rd(1'b1);
      rd(1'b1);
      drain();
      done_test("select_enable");
      for (int m = 0; m < 2; m++) begin
         do_reset(1'b0, m[0]);
         u_ohi_host_model.ser_byte(1'b1, 8'ha5, 3);
         for (int i = 0; i < 3; i++) begin
            st = lfsr_next(st);
            exp_q.push_back({st[8], st[7:0]});
            u_ohi_host_model.ser_byte(st[8], st[7:0], 8);
         end
         drain();
         done_test("serial");
      end
      report_and_stop();
   end
endmodule : testbench
